// *** core/bclr_regs.sv ***
// back-end control latch register bank behind a classic wishbone slave
//
// Added by the designer: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module bclr_regs
  import bclr_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // wishbone classic slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [BCLR_AW-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic err_o,
  // effective settings toward the video back end
  output logic sync_follow_input_o,
  output logic sync_free_run_o,
  output logic active_video_flag_prog_length_o,
  output logic [BCLR_DW-1:0] window_one_o,
  output logic [BCLR_DW-1:0] window_two_o,
  output logic [BCLR_DW-1:0] decim_frames_o,
  output logic [1:0] out_format_o,
  output logic fmt_sep_sync_o,
  output logic fmt_emb_hdr_o,
  output logic embedded_timing_code_stream_o
);
  // ********************************************************
  // bus decode
  // ********************************************************
  logic req;
  logic wr_lo;
  logic wr_hi;
  logic hit_ctrl;
  logic hit_info;
  logic hit_fmt;
  logic hit_w1;
  logic hit_w2;
  logic hit_td;
  logic hit_w1a;
  logic hit_w2a;
  logic hit_tda;
  logic mapped;
  logic [11:0] wdata;

  // request seen once; ack clears next cycle so no double take
  assign req = cyc_i && stb_i && !ack_o && !err_o;
  assign hit_ctrl = (adr_i == BCLR_ADR_CTRL);
  assign hit_info = (adr_i == BCLR_ADR_INFO);
  assign hit_fmt = (adr_i == BCLR_ADR_FMT);
  assign hit_w1 = (adr_i == BCLR_ADR_WIN1);
  assign hit_w2 = (adr_i == BCLR_ADR_WIN2);
  assign hit_td = (adr_i == BCLR_ADR_TDEC);
  assign hit_w1a = (adr_i == BCLR_ADR_WIN1_ACT);
  assign hit_w2a = (adr_i == BCLR_ADR_WIN2_ACT);
  assign hit_tda = (adr_i == BCLR_ADR_TDEC_ACT);
  assign mapped = hit_ctrl | hit_info | hit_fmt | hit_w1 | hit_w2 | hit_td | hit_w1a | hit_w2a | hit_tda;
  // byte lane 0 carries bits 7:0, lane 1 bits 11:8
  // lanes 2 and 3 carry nothing; a lane-1-only write can latch but not store
  assign wr_lo = req && we_i && sel_i[0] && ce_i;
  assign wr_hi = req && we_i && sel_i[1] && ce_i;
  assign wdata = dat_i[11:0];

  // ********************************************************
  // control word and pending values
  // ********************************************************
  logic [11:0] ctrl_reg;
  logic [11:0] ctrl_next;
  logic [11:0] fmt_reg;
  logic [11:0] fmt_next;
  logic [11:0] w1p_reg;
  logic [11:0] w1p_next;
  logic [11:0] w2p_reg;
  logic [11:0] w2p_next;
  logic [11:0] tdp_reg;
  logic [11:0] tdp_next;
  logic [1:0] tm_act_reg;
  logic [1:0] tm_act_next;
  logic active_video_flag_act_reg;
  logic active_video_flag_act_next;
  logic c_win1;
  logic c_win2;
  logic c_tdec;
  logic c_tm;

  // latch bits never stored: they fire a one-cycle commit and read back 0
  assign c_win1 = wr_lo && hit_ctrl && wdata[BCLR_F_WIN1];
  assign c_win2 = wr_lo && hit_ctrl && wdata[BCLR_F_WIN2];
  assign c_tdec = wr_hi && hit_ctrl && wdata[BCLR_F_TDEC];
  assign c_tm = wr_hi && hit_ctrl && wdata[BCLR_F_TM];

  // register writes; reserved control bits dropped so a careless write does no harm (format and pending registers keep all 12 bits)
  always_comb begin
    ctrl_next = ctrl_reg;
    fmt_next = fmt_reg;
    w1p_next = w1p_reg;
    w2p_next = w2p_reg;
    tdp_next = tdp_reg;
    if (wr_lo && hit_ctrl) begin
      ctrl_next = wdata & BCLR_CTRL_WMASK;
    end
    if (wr_lo && hit_fmt) begin
      fmt_next[7:0] = wdata[7:0];
    end
    if (wr_hi && hit_fmt) begin
      fmt_next[11:8] = wdata[11:8];
    end
    if (wr_lo && hit_w1) begin
      w1p_next[7:0] = wdata[7:0];
    end
    if (wr_hi && hit_w1) begin
      w1p_next[11:8] = wdata[11:8];
    end
    if (wr_lo && hit_w2) begin
      w2p_next[7:0] = wdata[7:0];
    end
    if (wr_hi && hit_w2) begin
      w2p_next[11:8] = wdata[11:8];
    end
    if (wr_lo && hit_td) begin
      tdp_next[7:0] = wdata[7:0];
    end
    if (wr_hi && hit_td) begin
      tdp_next[11:8] = wdata[11:8];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= BCLR_RST_CTRL;
      fmt_reg <= BCLR_RST_FMT;
      w1p_reg <= BCLR_RST_VAL;
      w2p_reg <= BCLR_RST_VAL;
      tdp_reg <= BCLR_RST_VAL;
    end else if (ce_i) begin
      ctrl_reg <= ctrl_next;
      fmt_reg <= fmt_next;
      w1p_reg <= w1p_next;
      w2p_reg <= w2p_next;
      tdp_reg <= tdp_next;
    end
  end

  // ********************************************************
  // timing mode in effect
  // ********************************************************
  // a timing write carrying its own latch bit takes the new value at once
  // active_video_flag mode rides on the timing latch, so the state word never shows a half-set mode
  always_comb begin
    tm_act_next = tm_act_reg;
    active_video_flag_act_next = active_video_flag_act_reg;
    if (c_tm) begin
      tm_act_next = ctrl_next[BCLR_F_SYNC_HI:BCLR_F_SYNC_LO];
      active_video_flag_act_next = ctrl_next[BCLR_F_ACTIVE_VIDEO_FLAG];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tm_act_reg <= BCLR_SYNC_OPEN;
      active_video_flag_act_reg <= 1'b0;
    end else if (ce_i) begin
      tm_act_reg <= tm_act_next;
      active_video_flag_act_reg <= active_video_flag_act_next;
    end
  end

  // ********************************************************
  // window and decimation shadows
  // ********************************************************
  logic [2:0][11:0] cm_pending;
  logic [2:0] cm_commit;
  logic [11:0] cm_active [3];

  // a commit in the same cycle as a pending write takes the newly written value
  assign cm_pending = {tdp_next, w2p_next, w1p_next};
  assign cm_commit = {c_tdec, c_win2, c_win1};

  // one shadow per channel: 0 window one, 1 window two, 2 decimation
  for (genvar g = 0; g < 3; g++) begin : g_shadow
    bclr_commit_if #(.W(12)) ch ();
    assign ch.pending = cm_pending[g];
    assign ch.commit = cm_commit[g];
    assign cm_active[g] = ch.active;
    bclr_shadow #(.RST(BCLR_RST_VAL)) u_shadow (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .ch(ch)
    );
  end

  // ********************************************************
  // state word and read mux
  // ********************************************************
  logic [11:0] info_word;
  logic [11:0] rdata;

  // state word reflects what is in force, not what was last written
  always_comb begin
    info_word = 12'h000;
    info_word[BCLR_F_SYNC_HI:BCLR_F_SYNC_LO] = tm_act_reg;
    info_word[BCLR_F_ACTIVE_VIDEO_FLAG] = active_video_flag_act_reg;
  end

  // control reads return stored fields; latch bits always 0
  always_comb begin
    rdata = 12'h000;
    if (hit_ctrl) begin
      rdata = ctrl_reg;
    end else if (hit_info) begin
      rdata = info_word;
    end else if (hit_fmt) begin
      rdata = fmt_reg;
    end else if (hit_w1) begin
      rdata = w1p_reg;
    end else if (hit_w2) begin
      rdata = w2p_reg;
    end else if (hit_td) begin
      rdata = tdp_reg;
    end else if (hit_w1a) begin
      rdata = cm_active[0];
    end else if (hit_w2a) begin
      rdata = cm_active[1];
    end else if (hit_tda) begin
      rdata = cm_active[2];
    end
  end

  // ********************************************************
  // bus answer
  // ********************************************************
  logic ack_reg;
  logic ack_next;
  logic err_reg;
  logic err_next;
  logic [31:0] dat_reg;
  logic [31:0] dat_next;

  // one-cycle answer; writes to the state word are ignored but acked
  always_comb begin
    ack_next = 1'b0;
    err_next = 1'b0;
    dat_next = dat_reg;
    if (req) begin
      ack_next = mapped;
      err_next = !mapped;
      dat_next = {20'h00000, rdata};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      err_reg <= 1'b0;
      dat_reg <= 32'h00000000;
    end else if (ce_i) begin
      ack_reg <= ack_next;
      err_reg <= err_next;
      dat_reg <= dat_next;
    end
  end

  assign ack_o = ack_reg;
  assign err_o = err_reg;
  assign dat_o = dat_reg;

  // ********************************************************
  // effective outputs
  // ********************************************************
  bclr_out_fmt_t fmt_sel;
  logic follow_reg;
  logic follow_next;
  logic free_reg;
  logic free_next;
  logic [2:0] fmt_dec_reg;
  logic [2:0] fmt_dec_next;

  // unknown format code 11 drives no format strobe; decoded from the next value
  always_comb begin
    case (fmt_next[BCLR_F_FMT_HI:BCLR_F_FMT_LO])
      BCLR_FMT_SEP: fmt_sel = BCLR_OUT_SEP_SYNC;
      BCLR_FMT_EMB_HDR: fmt_sel = BCLR_OUT_EMB_HDR;
      BCLR_FMT_TCODE: fmt_sel = BCLR_OUT_TCODE;
      default: fmt_sel = BCLR_OUT_NONE;
    endcase
  end

  // strobes decoded one step ahead and registered, so they move with their field, glitch free
  always_comb begin
    follow_next = (tm_act_next == BCLR_SYNC_OPEN);
    free_next = (tm_act_next == BCLR_SYNC_SCAN);
    fmt_dec_next = 3'b000;
    fmt_dec_next[0] = (fmt_sel == BCLR_OUT_SEP_SYNC);
    fmt_dec_next[1] = (fmt_sel == BCLR_OUT_EMB_HDR);
    fmt_dec_next[2] = (fmt_sel == BCLR_OUT_TCODE);
  end

  // reset values match the reset codes: open mode and separate syncs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      follow_reg <= 1'b1;
      free_reg <= 1'b0;
      fmt_dec_reg <= 3'b001;
    end else if (ce_i) begin
      follow_reg <= follow_next;
      free_reg <= free_next;
      fmt_dec_reg <= fmt_dec_next;
    end
  end

  assign sync_follow_input_o = follow_reg;
  assign sync_free_run_o = free_reg;
  assign active_video_flag_prog_length_o = active_video_flag_act_reg;
  assign window_one_o = cm_active[0];
  assign window_two_o = cm_active[1];
  assign decim_frames_o = cm_active[2];
  assign out_format_o = fmt_reg[BCLR_F_FMT_HI:BCLR_F_FMT_LO];
  assign fmt_sep_sync_o = fmt_dec_reg[0];
  assign fmt_emb_hdr_o = fmt_dec_reg[1];
  assign embedded_timing_code_stream_o = fmt_dec_reg[2];
endmodule // bclr_regs
`default_nettype wire

// *** include/bclr_pkg.sv ***
// package: register map, field layout and encodings of the back-end control latch bank
package bclr_pkg;
  // ********************************************************
  // register offsets (word index) and byte addresses
  // ********************************************************
  localparam logic [8:0] BCLR_IDX_CTRL = 9'h140;
  localparam logic [8:0] BCLR_IDX_INFO = 9'h141;
  localparam logic [8:0] BCLR_IDX_FMT = 9'h150;
  localparam int BCLR_AW = 11;
  localparam logic [10:0] BCLR_ADR_CTRL = {BCLR_IDX_CTRL, 2'b00};
  localparam logic [10:0] BCLR_ADR_INFO = {BCLR_IDX_INFO, 2'b00};
  localparam logic [10:0] BCLR_ADR_FMT = {BCLR_IDX_FMT, 2'b00};
  // extra registers: pending window / decimation values and their active copies
  localparam logic [10:0] BCLR_ADR_WIN1 = 11'h600;
  localparam logic [10:0] BCLR_ADR_WIN2 = 11'h604;
  localparam logic [10:0] BCLR_ADR_TDEC = 11'h608;
  localparam logic [10:0] BCLR_ADR_WIN1_ACT = 11'h610;
  localparam logic [10:0] BCLR_ADR_WIN2_ACT = 11'h614;
  localparam logic [10:0] BCLR_ADR_TDEC_ACT = 11'h618;
  // ********************************************************
  // field layout
  // ********************************************************
  localparam int BCLR_DW = 12;
  localparam int BCLR_F_SYNC_LO = 0;
  localparam int BCLR_F_SYNC_HI = 1;
  localparam int BCLR_F_ACTIVE_VIDEO_FLAG = 2;
  localparam int BCLR_F_WIN1 = 5;
  localparam int BCLR_F_WIN2 = 6;
  localparam int BCLR_F_TDEC = 10;
  localparam int BCLR_F_TM = 11;
  localparam int BCLR_F_FMT_LO = 0;
  localparam int BCLR_F_FMT_HI = 1;
  // writable control bits: sync mode and active_video_flag mode (latches and reserved masked)
  localparam logic [11:0] BCLR_CTRL_WMASK = 12'h007;
  // ********************************************************
  // reset values
  // ********************************************************
  localparam logic [11:0] BCLR_RST_CTRL = 12'h000;
  localparam logic [11:0] BCLR_RST_FMT = 12'h000;
  localparam logic [11:0] BCLR_RST_VAL = 12'h000;
  // ********************************************************
  // encodings
  // ********************************************************
  localparam logic [1:0] BCLR_SYNC_OPEN = 2'b00;
  localparam logic [1:0] BCLR_SYNC_SCAN = 2'b10;
  localparam logic [1:0] BCLR_FMT_SEP = 2'b00;
  localparam logic [1:0] BCLR_FMT_EMB_HDR = 2'b01;
  localparam logic [1:0] BCLR_FMT_TCODE = 2'b10;
  typedef enum logic [1:0] {
    BCLR_OUT_SEP_SYNC,
    BCLR_OUT_EMB_HDR,
    BCLR_OUT_TCODE,
    BCLR_OUT_NONE
  } bclr_out_fmt_t;
endpackage

// *** include/bclr_commit_if.sv ***
// interface: one pending-to-active commit channel between top and shadow module
`timescale 1ns/1ps
`default_nettype none
interface bclr_commit_if #(parameter int W = 12);
  logic [W-1:0] pending;
  logic commit;
  logic [W-1:0] active;
  modport src (output pending, output commit, input active);
  modport dst (input pending, input commit, output active);
endinterface
`default_nettype wire

// *** core/bclr_shadow.sv ***
// shadow register: takes the pending value into the active copy on a commit pulse
`timescale 1ns/1ps
`default_nettype none
module bclr_shadow
  import bclr_pkg::*;
#(
  parameter logic [11:0] RST = 12'h000
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  bclr_commit_if.dst ch
);
  logic [11:0] active_reg;
  logic [11:0] active_next;

  // active value moves only on commit so the video path never sees half edits
  always_comb begin
    active_next = active_reg;
    if (ch.commit) begin
      active_next = ch.pending;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      active_reg <= RST;
    end else if (ce_i) begin
      active_reg <= active_next;
    end
  end

  assign ch.active = active_reg;
endmodule // bclr_shadow
`default_nettype wire

// *** dv/bclr_regs_checker.sv ***
// checker: bus answer, commit and decode assertions of the latch register bank
`timescale 1ns/1ps
`default_nettype none
module bclr_regs_checker
  import bclr_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [BCLR_AW-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic err_o,
  input wire logic sync_follow_input_o,
  input wire logic sync_free_run_o,
  input wire logic active_video_flag_prog_length_o,
  input wire logic [BCLR_DW-1:0] window_one_o,
  input wire logic [BCLR_DW-1:0] window_two_o,
  input wire logic [BCLR_DW-1:0] decim_frames_o,
  input wire logic [1:0] out_format_o,
  input wire logic fmt_sep_sync_o,
  input wire logic fmt_emb_hdr_o,
  input wire logic embedded_timing_code_stream_o
);
  logic take;
  logic ctrl_wr;
  // a request is taken only while no answer is pending
  assign take = cyc_i && stb_i && ce_i && !ack_o && !err_o;
  assign ctrl_wr = take && we_i && adr_i == BCLR_ADR_CTRL;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ********************************************************
  // bus answer
  // ********************************************************
  a_ack_pulse: assert property (ack_o && ce_i |=> !ack_o)
    else $error("ack held longer than one cycle");
  a_ctrl_answer: assert property (take && adr_i == BCLR_ADR_CTRL |=> ack_o && !err_o)
    else $error("control access not acknowledged");
  a_answer_cause: assert property ($rose(ack_o) |-> $past(take))
    else $error("ack without a taken request");
  a_read_upper: assert property (ack_o |-> dat_o[31:12] == 20'h0)
    else $error("upper read bits not zero");
  // ********************************************************
  // commits and decodes
  // ********************************************************
  a_sync_value: assert property ($past(ctrl_wr && dat_i[BCLR_F_TM] && sel_i[1] && sel_i[0]) |->
    sync_free_run_o == ($past(dat_i[1:0]) == BCLR_SYNC_SCAN) &&
    sync_follow_input_o == ($past(dat_i[1:0]) == BCLR_SYNC_OPEN))
    else $error("timing mode outputs differ from latched code");
  a_mode_latch: assert property ($changed(sync_free_run_o) || $changed(active_video_flag_prog_length_o) |->
    $past(ctrl_wr && dat_i[BCLR_F_TM] && sel_i[1]))
    else $error("timing or active_video_flag mode moved without latch");
  a_win1_commit: assert property ($changed(window_one_o) |-> $past(ctrl_wr && dat_i[BCLR_F_WIN1] && sel_i[0]))
    else $error("window one moved without latch");
  a_win2_commit: assert property ($changed(window_two_o) |-> $past(ctrl_wr && dat_i[BCLR_F_WIN2] && sel_i[0]))
    else $error("window two moved without latch");
  a_decim_commit: assert property ($changed(decim_frames_o) |-> $past(ctrl_wr && dat_i[BCLR_F_TDEC] && sel_i[1]))
    else $error("decimation count moved without latch");
  a_fmt_decode: assert property (fmt_sep_sync_o == (out_format_o == BCLR_FMT_SEP) &&
    fmt_emb_hdr_o == (out_format_o == BCLR_FMT_EMB_HDR) &&
    embedded_timing_code_stream_o == (out_format_o == BCLR_FMT_TCODE))
    else $error("format decode mismatch");
endmodule // bclr_regs_checker
bind bclr_regs bclr_regs_checker bclr_regs_checker_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
  .ack_o(ack_o), .err_o(err_o), .sync_follow_input_o(sync_follow_input_o), .sync_free_run_o(sync_free_run_o),
  .active_video_flag_prog_length_o(active_video_flag_prog_length_o), .window_one_o(window_one_o), .window_two_o(window_two_o),
  .decim_frames_o(decim_frames_o), .out_format_o(out_format_o), .fmt_sep_sync_o(fmt_sep_sync_o),
  .fmt_emb_hdr_o(fmt_emb_hdr_o), .embedded_timing_code_stream_o(embedded_timing_code_stream_o));
`default_nettype wire

// *** dv/tb.sv ***
// testbench: wishbone register-level tests of the latch register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
  import bclr_pkg::*;
  logic clk_i, rst_i, ce_i, cyc_i, stb_i, we_i, ack_o, err_o, berr;
  logic sfi, sfr, vpl, fsep, femb, ftc;
  logic [10:0] adr_i;
  logic [3:0] sel_i;
  logic [31:0] dat_i, dat_o, rd;
  logic [11:0] w1, w2, dec;
  logic [1:0] fmt;
  int num_errors, checks;
  bclr_regs bclr_regs_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
    .sync_follow_input_o(sfi), .sync_free_run_o(sfr), .active_video_flag_prog_length_o(vpl), .window_one_o(w1),
    .window_two_o(w2), .decim_frames_o(dec), .out_format_o(fmt), .fmt_sep_sync_o(fsep),
    .fmt_emb_hdr_o(femb), .embedded_timing_code_stream_o(ftc));
  // ********************************************************
  // helpers
  // ********************************************************
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // one classic cycle; one idle edge after release so strobes never re-rise in the same step
  task automatic wb(input logic w, input logic [10:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hf;
    do begin
      @(posedge clk_i);
      n++;
    end while (!(ack_o || err_o) && n < 20);
    if (n >= 20) check("bus answer", 32'h0, 32'h1);
    rd = dat_o;
    berr = err_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic final_report;
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ********************************************************
  // clock and watchdog
  // ********************************************************
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // whole run needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge clk_i);
    num_errors++;
    final_report();
  end
  // ********************************************************
  // tests
  // ********************************************************
  initial begin
    rst_i = 1'b1;
    ce_i = 1'b1;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i = 1'b0;
    adr_i = 11'h000;
    sel_i = 4'h0;
    dat_i = 32'h0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check("follow", sfi, 32'h1);
    check("free", sfr, 32'h0);
    check("fmt", {fsep, fmt}, 32'h4);
    wb(1'b0, BCLR_ADR_CTRL, 32'h0);
    check("ctrl", rd, 32'h0);
    check("err", berr, 32'h0);
    wb(1'b0, BCLR_ADR_INFO, 32'h0);
    check("info", rd, 32'h0);
    // pending mode must stay out of effect until the latch bit
    wb(1'b1, BCLR_ADR_CTRL, 32'h006);
    check("free", {sfr, vpl}, 32'h0);
    wb(1'b0, BCLR_ADR_CTRL, 32'h0);
    check("ctrl", rd, 32'h006);
    wb(1'b1, BCLR_ADR_CTRL, 32'h806);
    check("modes", {sfi, sfr, vpl}, 32'h3);
    wb(1'b0, BCLR_ADR_CTRL, 32'h0);
    check("ctrl", rd, 32'h006);
    wb(1'b0, BCLR_ADR_INFO, 32'h0);
    check("info", rd, 32'h006);
    wb(1'b1, BCLR_ADR_CTRL, 32'h800);
    check("modes", {sfi, sfr, vpl}, 32'h4);
    wb(1'b0, BCLR_ADR_INFO, 32'h0);
    check("info", rd, 32'h0);
    wb(1'b1, BCLR_ADR_CTRL, 32'h004);
    wb(1'b0, BCLR_ADR_CTRL, 32'h0);
    check("ctrl", rd, 32'h004);
    // pending value, then its latch bit, for each commit channel
    for (int i = 0; i < 3; i++) begin
      wb(1'b1, BCLR_ADR_WIN1 + 11'(4 * i), 32'h5a0 + i);
      wb(1'b0, BCLR_ADR_WIN1_ACT + 11'(4 * i), 32'h0);
      check("active", rd, 32'h0);
      wb(1'b1, BCLR_ADR_CTRL, (i == 0) ? 32'h020 : (i == 1) ? 32'h040 : 32'h400);
      wb(1'b0, BCLR_ADR_WIN1_ACT + 11'(4 * i), 32'h0);
      check("active", rd, 32'h5a0 + i);
      wb(1'b0, BCLR_ADR_CTRL, 32'h0);
      check("ctrl", rd, 32'h0);
    end
    check("window one", {20'h00000, w1}, 32'h5a0);
    check("window two", {20'h00000, w2}, 32'h5a1);
    check("decimation", {20'h00000, dec}, 32'h5a2);
    // every format code, the unused one included
    for (int f = 0; f < 4; f++) begin
      wb(1'b1, BCLR_ADR_FMT, 32'(f));
      check("fmt", {fmt, fsep, femb, ftc}, {f[1:0], f == 0, f == 1, f == 2});
    end
    wb(1'b1, 11'h7fc, 32'h0);
    check("err", berr, 32'h1);
    final_report();
  end
endmodule // tb
`default_nettype wire
